// >>> src/charger_type_classifier.sv
// charger detection, classification, outputs and register port
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module charger_type_classifier
  import chg_class_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       bus_power_valid_i,
  input  wire logic       primary_detect_i,
  input  wire logic       secondary_detect_i,
  input  wire logic [3:0] dplus_above_i,
  input  wire logic [3:0] dminus_above_i,
  input  wire logic       sbu1_80k_i,
  input  wire logic       sbu2_80k_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            dplus_source_voltage_o,
  output logic            dminus_sink_o,
  output logic      [1:0] base_charger_class_o,
  output logic      [2:0] proprietary_charger_class_o,
  output logic            detection_running_flag_o,
  output logic            charge_en_n_o,
  output logic            charge_en_n_oe_o,
  output logic            factory_boot_n_o,
  output logic            factory_boot_n_oe_o,
  output logic            irq_n_o,
  output logic            irq_n_oe_o
);

  typedef struct packed {
    det_state_type     st;
    logic [15:0]       cnt;
    logic              pwr_seen;
    logic              dp_src;
    logic              dm_sink;
    logic [1:0]        base;
    logic [2:0]        prop;
    logic              running;
    logic              ce_low;
    logic              boot_low;
    logic [7:0]        control;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq_low;
    logic [7:0]        rdata;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  det_if link ();

  logic [IRQ_W-1:0] ev;
  logic [3:0]       line_above [2];
  logic [2:0]       line_band  [2];

  //////////////////////////////////////////////////////////////////////////
  // band classification

  // index 0 is the d+ line, index 1 the d- line
  assign line_above[0] = dplus_above_i;
  assign line_above[1] = dminus_above_i;

  for (genvar g = 0; g < 2; g++) begin : g_line
    band_quantizer u_quant (
      .above_i (line_above[g]),
      .band_o  (line_band[g])
    );
  end

  assign link.dplus_band  = line_band[0];
  assign link.dminus_band = line_band[1];

  band_classifier u_class (
    .link (link.classifier)
  );

  function automatic logic [7:0] read_mux(input logic [3:0] a,
                                          input state_type s);
    case (a)
      ADDR_RESULT:   read_mux = {2'h0, s.running, s.prop, s.base};
      ADDR_CONTROL:  read_mux = s.control;
      ADDR_IRQ_STAT: read_mux = {5'h00, s.irq_stat};
      ADDR_IRQ_EN:   read_mux = {5'h00, s.irq_en};
      default:       read_mux = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;
    ev    = '0;
    s_nxt.pwr_seen = bus_power_valid_i;

    unique case (s_r.st)
      ST_IDLE: begin
        if (bus_power_valid_i && !s_r.pwr_seen) begin
          s_nxt.st      = ST_PRIMARY;
          s_nxt.running = 1'b1;
          s_nxt.dp_src  = 1'b1;
          s_nxt.cnt     = 16'(SETTLE_CNT);
          s_nxt.base    = BASE_NONE;
          s_nxt.prop    = PROP_UNKNOWN;
        end
      end
      ST_PRIMARY: begin
        if (s_r.cnt != 16'h0000) begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end else if (!primary_detect_i) begin
          s_nxt.base   = BASE_SDP;
          s_nxt.dp_src = 1'b0;
          s_nxt.st     = ST_SETTLE;
        end else begin
          s_nxt.dp_src  = 1'b0;
          s_nxt.dm_sink = 1'b1;
          s_nxt.cnt     = 16'(SETTLE_CNT);
          s_nxt.st      = ST_SECOND;
        end
      end
      ST_SECOND: begin
        if (s_r.cnt != 16'h0000) begin
          s_nxt.cnt = s_r.cnt - 16'h0001;
        end else begin
          s_nxt.base    = secondary_detect_i ? BASE_DCP : BASE_CDP;
          s_nxt.dm_sink = 1'b0;
          s_nxt.dp_src  = 1'b0;
          s_nxt.st      = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (link.prop_valid) begin
          s_nxt.prop = link.prop_class;
          s_nxt.base = link.prop_base;
        end
        s_nxt.st = ST_DONE;
      end
      ST_DONE: begin
        s_nxt.running = 1'b0;
        ev[IRQ_DONE]  = 1'b1;
        s_nxt.st      = ST_IDLE;
      end
    endcase

    if (!bus_power_valid_i) begin
      s_nxt.st      = ST_IDLE;
      s_nxt.base    = BASE_NONE;
      s_nxt.prop    = PROP_UNKNOWN;
      s_nxt.running = 1'b0;
      s_nxt.dp_src  = 1'b0;
      s_nxt.dm_sink = 1'b0;
      s_nxt.cnt     = 16'h0000;
    end
    if (bus_power_valid_i != s_r.pwr_seen) begin
      ev[IRQ_VBCHG] = 1'b1;
    end

    // charge enable from the class currently reported
    if (s_nxt.base == BASE_NONE) begin
      s_nxt.ce_low = 1'b0;
    end else if (s_nxt.base == BASE_SDP && s_nxt.prop == PROP_UNKNOWN) begin
      s_nxt.ce_low = s_nxt.control[0];
    end else begin
      s_nxt.ce_low = 1'b1;
    end

    s_nxt.boot_low = sbu1_80k_i | sbu2_80k_i;
    if (s_nxt.boot_low && !s_r.boot_low) begin
      ev[IRQ_BOOT] = 1'b1;
    end

    // register port: set beats clear
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CONTROL) begin
        s_nxt.control = reg_wdata_i;
      end
      if (reg_addr_i == ADDR_IRQ_EN) begin
        s_nxt.irq_en = reg_wdata_i[IRQ_W-1:0];
      end
      if (reg_addr_i == ADDR_IRQ_CLR) begin
        s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata_i[IRQ_W-1:0];
      end
    end
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.irq_low  = |(s_nxt.irq_stat & s_nxt.irq_en);
    s_nxt.rdata    = reg_rd_i ? read_mux(reg_addr_i, s_r) : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s_r.st       <= ST_IDLE;
      s_r.cnt      <= 16'h0000;
      s_r.pwr_seen <= 1'b0;
      s_r.dp_src   <= 1'b0;
      s_r.dm_sink  <= 1'b0;
      s_r.base     <= BASE_NONE;
      s_r.prop     <= PROP_UNKNOWN;
      s_r.running  <= 1'b0;
      s_r.ce_low   <= 1'b0;
      s_r.boot_low <= 1'b0;
      s_r.control  <= CONTROL_RST;
      s_r.irq_stat <= IRQ_RST;
      s_r.irq_en   <= IRQ_RST;
      s_r.irq_low  <= 1'b0;
      s_r.rdata    <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, open-drain pins drive only low

  assign reg_rdata_o                 = s_r.rdata;
  assign dplus_source_voltage_o      = s_r.dp_src;
  assign dminus_sink_o               = s_r.dm_sink;
  assign base_charger_class_o        = s_r.base;
  assign proprietary_charger_class_o = s_r.prop;
  assign detection_running_flag_o    = s_r.running;
  assign charge_en_n_o               = 1'b0;
  assign charge_en_n_oe_o            = s_r.ce_low;
  assign factory_boot_n_o            = 1'b0;
  assign factory_boot_n_oe_o         = s_r.boot_low;
  assign irq_n_o                     = 1'b0;
  assign irq_n_oe_o                  = s_r.irq_low;

endmodule

// >>> pkg/chg_class_pkg.sv
// constants and types for the charger type classifier
package chg_class_pkg;

  // base charger class codes
  localparam logic [1:0] BASE_NONE = 2'h0;
  localparam logic [1:0] BASE_SDP  = 2'h1;
  localparam logic [1:0] BASE_CDP  = 2'h2;
  localparam logic [1:0] BASE_DCP  = 2'h3;

  // proprietary class codes
  localparam logic [2:0] PROP_UNKNOWN = 3'h0;
  localparam logic [2:0] PROP_SHORT2A = 3'h1;
  localparam logic [2:0] PROP_HALF_A  = 3'h2;
  localparam logic [2:0] PROP_ONE_A   = 3'h3;
  localparam logic [2:0] PROP_TWO_A   = 3'h4;
  localparam logic [2:0] PROP_12W     = 3'h5;

  // line voltage bands, lowest first
  localparam logic [2:0] BAND_LOW  = 3'h0; // 0 to 0.32V
  localparam logic [2:0] BAND_B1   = 3'h1; // 0.32V to 31%
  localparam logic [2:0] BAND_B2   = 3'h2; // 31% to 47%
  localparam logic [2:0] BAND_B3   = 3'h3; // 47% to 64%
  localparam logic [2:0] BAND_HIGH = 3'h4; // 64% to 100%

  // register offsets
  localparam logic [3:0] ADDR_RESULT   = 4'h0;
  localparam logic [3:0] ADDR_CONTROL  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_EN   = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLR  = 4'h4;

  // interrupt bit positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_VBCHG = 1;
  localparam int IRQ_BOOT  = 2;
  localparam int IRQ_W     = 3;

  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] IRQ_RST     = 3'h0;

  // detection timing
  localparam int SETTLE_NS     = 1000;
  localparam int CLK_NS        = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_PRIMARY = 5'b00010,
    ST_SECOND  = 5'b00100,
    ST_SETTLE  = 5'b01000,
    ST_DONE    = 5'b10000
  } det_state_type;

endpackage

// >>> pkg/det_if.sv
// link between the detection engine and the band classifier
`timescale 1ns/1ps
interface det_if;
  logic [2:0] dplus_band;
  logic [2:0] dminus_band;
  logic [2:0] prop_class;
  logic [1:0] prop_base;
  logic       prop_valid;
  modport engine (input prop_class, input prop_base, input prop_valid);
  modport classifier (input  dplus_band,
                      input  dminus_band,
                      output prop_class,
                      output prop_base,
                      output prop_valid);
endinterface

// >>> src/band_classifier.sv
// maps d+/d- voltage bands to proprietary class and base class
`timescale 1ns/1ps
module band_classifier
  import chg_class_pkg::*;
(
  det_if.classifier link
);

  always_comb begin
    link.prop_class = PROP_UNKNOWN;
    link.prop_base  = BASE_NONE;
    link.prop_valid = 1'b0;
    if (link.dminus_band == BAND_B1 && link.dplus_band == BAND_B1) begin
      link.prop_class = PROP_SHORT2A;
      link.prop_base  = BASE_DCP;
      link.prop_valid = 1'b1;
    end else if (link.dminus_band == BAND_B2) begin
      if (link.dplus_band == BAND_B2) begin
        link.prop_class = PROP_HALF_A;
        link.prop_base  = BASE_SDP;
        link.prop_valid = 1'b1;
      end else if (link.dplus_band == BAND_B3) begin
        link.prop_class = PROP_TWO_A;
        link.prop_base  = BASE_SDP;
        link.prop_valid = 1'b1;
      end
    end else if (link.dminus_band == BAND_B3) begin
      if (link.dplus_band == BAND_B2) begin
        link.prop_class = PROP_ONE_A;
        link.prop_base  = BASE_CDP;
        link.prop_valid = 1'b1;
      end else if (link.dplus_band == BAND_B3) begin
        link.prop_class = PROP_12W;
        link.prop_base  = BASE_DCP;
        link.prop_valid = 1'b1;
      end
    end
  end

endmodule

// >>> src/band_quantizer.sv
// turns four threshold comparator outputs into a band code
`timescale 1ns/1ps
module band_quantizer
  import chg_class_pkg::*;
(
  input  wire logic [3:0] above_i,
  output logic      [2:0] band_o
);

  // thermometer code: bit0 0.32V, bit1 31%, bit2 47%, bit3 64%
  always_comb begin
    band_o = BAND_LOW;
    if (above_i[3]) begin
      band_o = BAND_HIGH;
    end else if (above_i[2]) begin
      band_o = BAND_B3;
    end else if (above_i[1]) begin
      band_o = BAND_B2;
    end else if (above_i[0]) begin
      band_o = BAND_B1;
    end
  end

endmodule

// >>> dv/chg_class_asserts.sv
// port checks for the charger type classifier
`timescale 1ns/1ps
module chg_class_asserts
  import chg_class_pkg::*;
#(
  parameter int SETTLE_CNT = 2
)
(
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       bus_power_valid_i,
  input wire logic       sbu1_80k_i,
  input wire logic       sbu2_80k_i,
  input wire logic       dplus_source_voltage_o,
  input wire logic [1:0] base_charger_class_o,
  input wire logic [2:0] proprietary_charger_class_o,
  input wire logic       detection_running_flag_o,
  input wire logic       charge_en_n_oe_o,
  input wire logic       factory_boot_n_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  function automatic logic [1:0] base_of(logic [2:0] p);
    return (p == 3'h3) ? BASE_CDP : (p == 3'h2 || p == 3'h4) ? BASE_SDP
           : BASE_DCP;
  endfunction
  a_ce_none: assert property (base_charger_class_o == BASE_NONE |->
    !charge_en_n_oe_o) else $error("ce pulled with no charger");
  a_ce_drive: assert property (base_charger_class_o != BASE_NONE &&
    !(base_charger_class_o == BASE_SDP &&
      proprietary_charger_class_o == PROP_UNKNOWN) |-> charge_en_n_oe_o)
    else $error("ce released for charger");
  a_prop_code: assert property (
    proprietary_charger_class_o <= PROP_12W)
    else $error("proprietary code out of range");
  a_prop_base: assert property (proprietary_charger_class_o !=
    PROP_UNKNOWN |-> base_charger_class_o ==
    base_of(proprietary_charger_class_o)) else $error("base mismatch");
  a_boot_follow: assert property (1 |=> factory_boot_n_oe_o ==
    $past(sbu1_80k_i | sbu2_80k_i)) else $error("boot pin wrong");
  a_run_start: assert property ($rose(bus_power_valid_i) |=>
    detection_running_flag_o) else $error("run not started");
  a_pwr_clear: assert property ($fell(bus_power_valid_i) |=>
    base_charger_class_o == BASE_NONE && !detection_running_flag_o &&
    proprietary_charger_class_o == PROP_UNKNOWN) else $error("no clear");
  a_src_idle: assert property (!detection_running_flag_o |->
    !dplus_source_voltage_o) else $error("d+ source left on");
  a_run_hold: assert property (detection_running_flag_o &&
    bus_power_valid_i && base_charger_class_o == BASE_NONE |=>
    detection_running_flag_o) else $error("running dropped early");
  c_prop_top: cover property (proprietary_charger_class_o == PROP_12W);
  c_cdp: cover property (base_charger_class_o == BASE_CDP);
  c_abort: cover property ($fell(bus_power_valid_i) &&
    detection_running_flag_o);
endmodule
bind charger_type_classifier
  chg_class_asserts #(.SETTLE_CNT(SETTLE_CNT)) chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .bus_power_valid_i(bus_power_valid_i), .sbu1_80k_i(sbu1_80k_i),
  .sbu2_80k_i(sbu2_80k_i), .dplus_source_voltage_o(dplus_source_voltage_o),
  .base_charger_class_o(base_charger_class_o),
  .proprietary_charger_class_o(proprietary_charger_class_o),
  .detection_running_flag_o(detection_running_flag_o),
  .charge_en_n_oe_o(charge_en_n_oe_o),
  .factory_boot_n_oe_o(factory_boot_n_oe_o));

// >>> dv/charger_model.sv
// attached charger: bus power, detect comparators and line bias
`timescale 1ns/1ps
module charger_model (
  input  wire logic       attach_i,
  input  wire logic       prim_cfg_i,
  input  wire logic       sec_cfg_i,
  input  wire logic [3:0] dp_cfg_i,
  input  wire logic [3:0] dm_cfg_i,
  input  wire logic       dp_src_i,
  input  wire logic       dm_sink_i,
  output logic            pwr_o,
  output logic            prim_o,
  output logic            sec_o,
  output logic      [3:0] dp_o,
  output logic      [3:0] dm_o
);
  // detect results only meaningful while probed, else misleading
  assign pwr_o  = attach_i;
  assign prim_o = dp_src_i ? prim_cfg_i : ~prim_cfg_i;
  assign sec_o  = dm_sink_i ? sec_cfg_i : ~sec_cfg_i;
  assign dp_o   = attach_i ? dp_cfg_i : 4'h0;
  assign dm_o   = attach_i ? dm_cfg_i : 4'h0;
endmodule

// >>> dv/tb.sv
// self-checking bench for the charger type classifier
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  import chg_class_pkg::*;
  typedef struct packed {
    logic [3:0] dp; logic [3:0] dm; logic p; logic s;
    logic [1:0] b; logic [2:0] c; logic ce;
  } row_type;
  logic clk = 0, srst = 1, att = 0, pc = 0, sc = 0, s1 = 0, s2 = 0;
  logic wr = 0, rd = 0, pwr, pr, se, dps, dms, run, ce, ceoe, fb, fboe;
  logic irq, irqoe;
  logic [3:0] dpc = 0, dmc = 0, dpa, dma, addr = 0;
  logic [7:0] wd = 0, rdat;
  logic [1:0] base;
  logic [2:0] prop;
  int err_count = 0, num_checks = 0;
  row_type rows [9] = '{
    '{4'h0, 4'h0, 1'b0, 1'b0, BASE_SDP, PROP_UNKNOWN, 1'b0},
    '{4'h0, 4'h0, 1'b1, 1'b0, BASE_CDP, PROP_UNKNOWN, 1'b1},
    '{4'h0, 4'h0, 1'b1, 1'b1, BASE_DCP, PROP_UNKNOWN, 1'b1},
    '{4'h1, 4'h1, 1'b1, 1'b1, BASE_DCP, PROP_SHORT2A, 1'b1},
    '{4'h3, 4'h3, 1'b0, 1'b0, BASE_SDP, PROP_HALF_A, 1'b1},
    '{4'h7, 4'h3, 1'b0, 1'b0, BASE_SDP, PROP_TWO_A, 1'b1},
    '{4'h3, 4'h7, 1'b0, 1'b0, BASE_CDP, PROP_ONE_A, 1'b1},
    '{4'h7, 4'h7, 1'b0, 1'b0, BASE_DCP, PROP_12W, 1'b1},
    '{4'hF, 4'hF, 1'b1, 1'b1, BASE_DCP, PROP_UNKNOWN, 1'b1}};
  charger_type_classifier #(.SETTLE_CNT(2)) uut (.sys_clk_i(clk),
    .srst_i(srst), .bus_power_valid_i(pwr), .primary_detect_i(pr),
    .secondary_detect_i(se), .dplus_above_i(dpa), .dminus_above_i(dma),
    .sbu1_80k_i(s1), .sbu2_80k_i(s2), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .dplus_source_voltage_o(dps), .dminus_sink_o(dms),
    .base_charger_class_o(base), .proprietary_charger_class_o(prop),
    .detection_running_flag_o(run), .charge_en_n_o(ce),
    .charge_en_n_oe_o(ceoe), .factory_boot_n_o(fb),
    .factory_boot_n_oe_o(fboe), .irq_n_o(irq), .irq_n_oe_o(irqoe));
  charger_model far (.attach_i(att), .prim_cfg_i(pc), .sec_cfg_i(sc),
    .dp_cfg_i(dpc), .dm_cfg_i(dmc), .dp_src_i(dps), .dm_sink_i(dms),
    .pwr_o(pwr), .prim_o(pr), .sec_o(se), .dp_o(dpa), .dm_o(dma));
  initial forever #5 clk = ~clk;
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); wr <= 1; addr <= a; wd <= d;
    @(posedge clk); wr <= 0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk); rd <= 1; addr <= a;
    @(posedge clk); rd <= 0;
    #1 d = rdat;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic detect(input row_type r);
    @(posedge clk); dpc <= r.dp; dmc <= r.dm; pc <= r.p; sc <= r.s;
    att <= 1;
    cyc(2);
    `CHK("running", 1'b1, run)
    for (int i = 0; i < 60 && run !== 1'b0; i++) cyc(1);
    `CHK("done", 1'b0, run)
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000 err_count++;
    results();
  end
  initial begin
    logic [7:0] d;
    repeat (2) @(posedge clk);
    srst <= 0;
    cyc(1);
    `CHK("base rst", BASE_NONE, base)
    `CHK("oe rst", 3'h0, {ceoe, fboe, irqoe})
    `CHK("od low", 3'h0, {ce, fb, irq})
    rreg(ADDR_CONTROL, d); `CHK("control", CONTROL_RST, d)
    rreg(ADDR_IRQ_STAT, d); `CHK("stat rst", 8'h00, d)
    rreg(4'hF, d); `CHK("unmapped", 8'h00, d)
    wreg(ADDR_IRQ_EN, 8'h01);
    foreach (rows[i]) begin
      detect(rows[i]);
      `CHK("base", rows[i].b, base)
      `CHK("prop", rows[i].c, prop)
      `CHK("ce", rows[i].ce, ceoe)
      `CHK("src", 1'b0, dps)
      rreg(ADDR_RESULT, d);
      `CHK("result", {3'h0, rows[i].c, rows[i].b}, d)
      `CHK("irq", 1'b1, irqoe)
      wreg(ADDR_IRQ_CLR, 8'h07); cyc(1);
      `CHK("irq clr", 1'b0, irqoe)
      @(posedge clk); att <= 0;
      cyc(3);
      `CHK("detach", 5'h00, {base, prop})
    end
    wreg(ADDR_CONTROL, 8'h01);
    rreg(ADDR_CONTROL, d); `CHK("ctl rd", 8'h01, d)
    detect(rows[0]);
    `CHK("ce allow", 1'b1, ceoe)
    @(posedge clk); att <= 0;
    detect(rows[7]);
    rreg(ADDR_RESULT, d); `CHK("run bit", 1'b0, d[5])
    @(posedge clk); att <= 1'b0; pc <= 1; dpc <= 4'h0; dmc <= 4'h0;
    cyc(2); @(posedge clk); att <= 1;
    cyc(4);
    `CHK("sink", 2'h1, {dps, dms})
    @(posedge clk); att <= 0;
    cyc(3);
    `CHK("abort", 7'h00, {dms, run, base, prop})
    rreg(ADDR_IRQ_STAT, d); `CHK("stat", 8'h03, d)
    wreg(ADDR_IRQ_CLR, 8'h07); wreg(ADDR_IRQ_EN, 8'h04);
    @(posedge clk); s1 <= 1;
    cyc(3);
    `CHK("boot1", 2'h3, {fboe, irqoe})
    wreg(ADDR_IRQ_EN, 8'h00); cyc(1);
    `CHK("irq mask", 1'b0, irqoe)
    @(posedge clk); s1 <= 0; s2 <= 1;
    cyc(2);
    `CHK("boot2", 1'b1, fboe)
    @(posedge clk); s2 <= 0;
    cyc(2);
    `CHK("boot off", 1'b0, fboe)
    @(posedge clk); att <= 1;
    cyc(3); @(posedge clk); srst <= 1;
    cyc(2);
    `CHK("rst mid", 8'h00, {dps, dms, run, base, prop})
    @(posedge clk); srst <= 0; att <= 0;
    cyc(2);
    `CHK("rst out", 3'h0, {ceoe, fboe, irqoe})
    results();
  end
endmodule
